// ==== rtl/fpp_consts.svh ====
/*
  Constants of the floating-point pipeline phase sequencer: instruction
  field positions, phase numbers, packet geometry and reset values.
  Assumes it is included by bare name from each file that uses its macros.
*/
`ifndef FPP_CONSTS_SVH
`define FPP_CONSTS_SVH

// Packet geometry
`define FPP_SLOTS       8
`define FPP_UNITS       8
`define FPP_INSN_W      32
`define FPP_PKT_W       256
`define FPP_PKT_STRIDE  32'h0000_0020
`define FPP_PC_RESET    32'h0000_0000

// Instruction word fields
`define FPP_CLS_LSB     0
`define FPP_CLS_W       4
`define FPP_UNIT_LSB    4
`define FPP_UNIT_W      3
`define FPP_PAR_BIT     7

// Execute phase numbers
`define FPP_E1          1
`define FPP_E2          2
`define FPP_E3          3
`define FPP_E4          4
`define FPP_E5          5
`define FPP_E6          6
`define FPP_E7          7
`define FPP_E9          9
`define FPP_E10         10
`define FPP_NUM_E       10

// One-hot class decode width
`define FPP_HOT_W       16

`endif

// ==== rtl/fpp_pkg.sv ====
/*
  Types of the floating-point pipeline phase sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fpp_pkg;

  typedef enum logic [3:0] {
    cls_nop          = 4'h0,
    cls_single       = 4'h1,
    cls_mpy16        = 4'h2,
    cls_store        = 4'h3,
    cls_load         = 4'h4,
    cls_branch       = 4'h5,
    cls_dp2          = 4'h6,
    cls_four         = 4'h7,
    cls_int_to_dbl   = 4'h8,
    cls_dp_cmp       = 4'h9,
    cls_dbl_addsub   = 4'ha,
    cls_int32_mpy    = 4'hb,
    cls_int_mpy_dbl  = 4'hc,
    cls_dbl_mpy      = 4'hd
  } fpp_class_t;

endpackage

// ==== rtl/fpp_fetch.sv ====
/*
  Program fetch phases: address generate, address send, access wait and
  packet receive. Assumes a synchronous program memory that returns the
  packet for prog_addr_o one cycle after it is presented.
*/
`timescale 1ns/1ps
`include "fpp_consts.svh"

module fpp_fetch (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  // Control from dispatch and branch
  input  wire logic                   advance_i,
  input  wire logic                   redirect_i,
  input  wire logic [31:0]            redirect_addr_i,
  // Program memory
  input  wire logic [`FPP_PKT_W-1:0]  prog_data_i,
  output logic      [31:0]            prog_addr_o,
  output logic                        prog_req_o,
  // Packet at the boundary
  output logic                        pr_valid_o,
  output logic      [`FPP_PKT_W-1:0]  pr_packet_o
);

  logic [31:0]            pg_addr;
  logic                   pw_valid;
  logic                   pw_fresh;
  logic [`FPP_PKT_W-1:0]  pw_data;

  // Memory answers once; hold it if the wait phase stalls
  wire [`FPP_PKT_W-1:0] pw_packet = pw_fresh ? prog_data_i : pw_data;
  wire [31:0] pg_step = 32'(pg_addr + `FPP_PKT_STRIDE);
  // Branch replaces the packet now in address generate
  wire [31:0] next_pg = redirect_i ? redirect_addr_i : (advance_i ? pg_step : pg_addr);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pg_addr     <= `FPP_PC_RESET;
      prog_addr_o <= `FPP_PC_RESET;
      prog_req_o  <= 1'b0;
      pw_valid    <= 1'b0;
      pw_fresh    <= 1'b0;
      pw_data     <= '0;
      pr_valid_o  <= 1'b0;
      pr_packet_o <= '0;
    end else begin
      pg_addr  <= next_pg;
      pw_fresh <= advance_i & prog_req_o;
      if (pw_fresh) begin
        pw_data <= prog_data_i;
      end
      if (advance_i) begin
        prog_addr_o <= pg_addr;
        prog_req_o  <= 1'b1;
        pw_valid    <= prog_req_o;
        pr_valid_o  <= pw_valid;
        pr_packet_o <= pw_packet;
      end
    end
  end

endmodule

// ==== rtl/fpp_exec_lane.sv ====
/*
  One functional unit's execute chain E1 to E10: carries the class of
  each live instruction one phase per cycle. Assumes the caller decodes
  the next-phase contents into registered events.
*/
`timescale 1ns/1ps
`include "fpp_consts.svh"

module fpp_exec_lane (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_n_i,
  // Instruction leaving decode
  input  wire logic                       enter_i,
  input  wire logic                       cond_i,
  input  wire logic [3:0]                 cls_i,
  // Next contents of each execute phase
  output logic      [`FPP_NUM_E:1]        next_live_o,
  output logic      [`FPP_NUM_E:1][3:0]   next_cls_o
);

  logic [`FPP_NUM_E:1]      live;
  logic [`FPP_NUM_E:1][3:0] cls;

  // False condition stops the instruction before E1
  assign next_live_o[`FPP_E1] = enter_i & cond_i;
  assign next_cls_o[`FPP_E1]  = cls_i;

  for (genvar k = `FPP_E2; k <= `FPP_NUM_E; k++) begin : g_chain
    assign next_live_o[k] = live[k-1];
    assign next_cls_o[k]  = cls[k-1];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      live <= '0;
      cls  <= '0;
    end else begin
      live <= next_live_o;
      cls  <= next_cls_o;
    end
  end

endmodule

// ==== rtl/fpp_pipeline.sv ====
/*
  Floating-point pipeline phase sequencer: fetch, dispatch, decode and
  ten execute phases, with per-unit registered phase events.
  Assumes a synchronous program memory, and that register files, units
  and data memory act on the event outputs in the cycle they are high.
*/
`timescale 1ns/1ps
`include "fpp_consts.svh"

module fpp_pipeline (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  // Program memory
  input  wire logic [`FPP_PKT_W-1:0]  prog_data_i,
  output logic      [31:0]            prog_addr_o,
  output logic                        prog_req_o,
  // From register files and units
  input  wire logic [`FPP_UNITS-1:0]  cond_i,
  input  wire logic [31:0]            br_target_i,
  input  wire logic [`FPP_UNITS-1:0]  sat_i,
  input  wire logic                   sat_clr_i,
  // Decode phase per unit
  output logic      [`FPP_UNITS-1:0]  dc_valid_o,
  // Operand reads per unit
  output logic      [`FPP_UNITS-1:0]  rd_full_o,
  output logic      [`FPP_UNITS-1:0]  rd_lo_o,
  output logic      [`FPP_UNITS-1:0]  rd_hi_o,
  output logic      [`FPP_UNITS-1:0]  rd_lo1_hi2_o,
  output logic      [`FPP_UNITS-1:0]  rd_hi1_lo2_o,
  // Register file writes per unit
  output logic      [`FPP_UNITS-1:0]  wr_full_o,
  output logic      [`FPP_UNITS-1:0]  wr_lo_o,
  output logic      [`FPP_UNITS-1:0]  wr_hi_o,
  // Address and data memory per unit
  output logic      [`FPP_UNITS-1:0]  agen_o,
  output logic      [`FPP_UNITS-1:0]  amod_wr_o,
  output logic      [`FPP_UNITS-1:0]  addr_send_o,
  output logic      [`FPP_UNITS-1:0]  wdata_send_o,
  output logic      [`FPP_UNITS-1:0]  mem_access_o,
  output logic      [`FPP_UNITS-1:0]  ld_return_o,
  output logic      [`FPP_UNITS-1:0]  ld_wr_o,
  // Completion, branch and saturation
  output logic      [`FPP_UNITS-1:0]  done_o,
  output logic      [`FPP_UNITS-1:0]  branch_o,
  output logic                        saturation_flag_o
);

  // Fetch and dispatch state
  logic                                 pr_valid;
  logic [`FPP_PKT_W-1:0]                pr_packet;
  logic                                 dp_valid;
  logic [`FPP_SLOTS-1:0][`FPP_INSN_W-1:0] dp_packet;
  logic [`FPP_SLOTS-1:0]                dp_left;
  logic [`FPP_SLOTS-1:0]                ep;
  logic [`FPP_SLOTS-1:0]                par;
  logic [`FPP_UNITS-1:0][3:0]           dc_cls;

  // Execute chain contents per unit
  logic [`FPP_UNITS-1:0][`FPP_NUM_E:1]      nl;
  logic [`FPP_UNITS-1:0][`FPP_NUM_E:1][3:0] nc;

  // Next values of the registered events
  logic [`FPP_UNITS-1:0] next_dc_valid;
  logic [`FPP_UNITS-1:0][3:0] next_dc_cls;
  logic [`FPP_UNITS-1:0] next_rd_full;
  logic [`FPP_UNITS-1:0] next_rd_lo;
  logic [`FPP_UNITS-1:0] next_rd_hi;
  logic [`FPP_UNITS-1:0] next_rd_lo1_hi2;
  logic [`FPP_UNITS-1:0] next_rd_hi1_lo2;
  logic [`FPP_UNITS-1:0] next_wr_full;
  logic [`FPP_UNITS-1:0] next_wr_lo;
  logic [`FPP_UNITS-1:0] next_wr_hi;
  logic [`FPP_UNITS-1:0] next_agen;
  logic [`FPP_UNITS-1:0] next_amod_wr;
  logic [`FPP_UNITS-1:0] next_addr_send;
  logic [`FPP_UNITS-1:0] next_wdata_send;
  logic [`FPP_UNITS-1:0] next_mem_access;
  logic [`FPP_UNITS-1:0] next_ld_return;
  logic [`FPP_UNITS-1:0] next_ld_wr;
  logic [`FPP_UNITS-1:0] next_done;
  logic [`FPP_UNITS-1:0] next_branch;
  logic [`FPP_UNITS-1:0] next_sat_set;

  // Execute packet: first remaining slot plus the parallel run after it
  for (genvar i = 0; i < `FPP_SLOTS; i++) begin : g_ep
    assign par[i] = dp_packet[i][`FPP_PAR_BIT];
    if (i == 0) begin : g_first
      assign ep[i] = dp_valid & dp_left[i];
    end else begin : g_rest
      assign ep[i] = dp_valid & dp_left[i] &
                     (!dp_left[i-1] | (ep[i-1] & par[i-1]));
    end
  end

  wire last_ep   = ((dp_left & ~ep) == '0);
  wire dp_adv    = !dp_valid | last_ep;
  wire redirect  = |next_branch;

  fpp_fetch u_fetch (
    .core_clk_i      (core_clk_i),
    .rst_n_i         (rst_n_i),
    .advance_i       (dp_adv),
    .redirect_i      (redirect),
    .redirect_addr_i (br_target_i),
    .prog_data_i     (prog_data_i),
    .prog_addr_o     (prog_addr_o),
    .prog_req_o      (prog_req_o),
    .pr_valid_o      (pr_valid),
    .pr_packet_o     (pr_packet)
  );

  // Route each dispatched instruction to the unit its word names
  for (genvar u = 0; u < `FPP_UNITS; u++) begin : g_unit
    logic [`FPP_SLOTS-1:0] hit;
    logic [`FPP_NUM_E:1][`FPP_HOT_W-1:0] h;
    logic [`FPP_HOT_W-1:0] e1;

    for (genvar i = 0; i < `FPP_SLOTS; i++) begin : g_hit
      assign hit[i] = ep[i] &
        (dp_packet[i][`FPP_UNIT_LSB +: `FPP_UNIT_W] == `FPP_UNIT_W'(u)) &
        (dp_packet[i][`FPP_CLS_LSB +: `FPP_CLS_W] != fpp_pkg::cls_nop);
    end

    always_comb begin
      next_dc_cls[u] = 4'h0;
      for (int i = 0; i < `FPP_SLOTS; i++) begin
        next_dc_cls[u] = next_dc_cls[u] |
          (hit[i] ? dp_packet[i][`FPP_CLS_LSB +: `FPP_CLS_W] : 4'h0);
      end
    end
    assign next_dc_valid[u] = |hit;

    fpp_exec_lane u_lane (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .enter_i     (dc_valid_o[u]),
      .cond_i      (cond_i[u]),
      .cls_i       (dc_cls[u]),
      .next_live_o (nl[u]),
      .next_cls_o  (nc[u])
    );

    // One-hot class per phase, live instructions only
    for (genvar k = `FPP_E1; k <= `FPP_NUM_E; k++) begin : g_hot
      assign h[k] = nl[u][k] ? (`FPP_HOT_W'(1) << nc[u][k]) : '0;
    end
    // E1 reads happen whatever the condition
    assign e1 = dc_valid_o[u] ? (`FPP_HOT_W'(1) << dc_cls[u]) : '0;

    assign next_rd_lo[u] = e1[fpp_pkg::cls_dp_cmp] | e1[fpp_pkg::cls_dbl_addsub] |
                           e1[fpp_pkg::cls_dbl_mpy];
    assign next_rd_full[u] = (dc_valid_o[u] & !next_rd_lo[u] &
                              !e1[fpp_pkg::cls_nop]) |
      h[`FPP_E2][fpp_pkg::cls_int32_mpy] | h[`FPP_E2][fpp_pkg::cls_int_mpy_dbl] |
      h[`FPP_E3][fpp_pkg::cls_int32_mpy] | h[`FPP_E3][fpp_pkg::cls_int_mpy_dbl] |
      h[`FPP_E4][fpp_pkg::cls_int32_mpy] | h[`FPP_E4][fpp_pkg::cls_int_mpy_dbl];
    assign next_rd_hi[u] = h[`FPP_E2][fpp_pkg::cls_dp_cmp] |
                           h[`FPP_E2][fpp_pkg::cls_dbl_addsub] |
                           h[`FPP_E4][fpp_pkg::cls_dbl_mpy];
    assign next_rd_lo1_hi2[u] = h[`FPP_E2][fpp_pkg::cls_dbl_mpy];
    assign next_rd_hi1_lo2[u] = h[`FPP_E3][fpp_pkg::cls_dbl_mpy];

    assign next_wr_full[u] = h[`FPP_E1][fpp_pkg::cls_single] |
                             h[`FPP_E2][fpp_pkg::cls_mpy16] |
                             h[`FPP_E2][fpp_pkg::cls_dp_cmp] |
                             h[`FPP_E4][fpp_pkg::cls_four] |
                             h[`FPP_E9][fpp_pkg::cls_int32_mpy];
    assign next_wr_lo[u] = h[`FPP_E1][fpp_pkg::cls_dp2] |
                           h[`FPP_E4][fpp_pkg::cls_int_to_dbl] |
                           h[`FPP_E6][fpp_pkg::cls_dbl_addsub] |
                           h[`FPP_E9][fpp_pkg::cls_int_mpy_dbl] |
                           h[`FPP_E9][fpp_pkg::cls_dbl_mpy];
    assign next_wr_hi[u] = h[`FPP_E2][fpp_pkg::cls_dp2] |
                           h[`FPP_E5][fpp_pkg::cls_int_to_dbl] |
                           h[`FPP_E7][fpp_pkg::cls_dbl_addsub] |
                           h[`FPP_E10][fpp_pkg::cls_int_mpy_dbl] |
                           h[`FPP_E10][fpp_pkg::cls_dbl_mpy];

    assign next_agen[u] = e1[fpp_pkg::cls_load] | e1[fpp_pkg::cls_store];
    assign next_amod_wr[u] = h[`FPP_E1][fpp_pkg::cls_load] |
                             h[`FPP_E1][fpp_pkg::cls_store];
    assign next_addr_send[u] = h[`FPP_E2][fpp_pkg::cls_load] |
                               h[`FPP_E2][fpp_pkg::cls_store];
    assign next_wdata_send[u] = h[`FPP_E2][fpp_pkg::cls_store];
    assign next_mem_access[u] = h[`FPP_E3][fpp_pkg::cls_load] |
                                h[`FPP_E3][fpp_pkg::cls_store];
    assign next_ld_return[u] = h[`FPP_E4][fpp_pkg::cls_load];
    assign next_ld_wr[u] = h[`FPP_E5][fpp_pkg::cls_load];
    assign next_branch[u] = h[`FPP_E1][fpp_pkg::cls_branch];

    assign next_done[u] = h[`FPP_E1][fpp_pkg::cls_single] |
      h[`FPP_E2][fpp_pkg::cls_mpy16] | h[`FPP_E2][fpp_pkg::cls_dp2] |
      h[`FPP_E2][fpp_pkg::cls_dp_cmp] | h[`FPP_E3][fpp_pkg::cls_store] |
      h[`FPP_E4][fpp_pkg::cls_four] | h[`FPP_E5][fpp_pkg::cls_load] |
      h[`FPP_E5][fpp_pkg::cls_int_to_dbl] | h[`FPP_E7][fpp_pkg::cls_dbl_addsub] |
      h[`FPP_E9][fpp_pkg::cls_int32_mpy] | h[`FPP_E10][fpp_pkg::cls_int_mpy_dbl] |
      h[`FPP_E10][fpp_pkg::cls_dbl_mpy];

    // Unit reports saturation in E1 (single) or E2 (multiply)
    assign next_sat_set[u] = sat_i[u] & (h[`FPP_E2][fpp_pkg::cls_single] |
                                         h[`FPP_E3][fpp_pkg::cls_mpy16]);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_valid  <= 1'b0;
      dp_packet <= '0;
      dp_left   <= '0;
    end else if (dp_adv) begin
      dp_valid  <= pr_valid;
      dp_packet <= pr_packet;
      dp_left   <= '1;
    end else begin
      dp_left   <= dp_left & ~ep;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dc_valid_o        <= '0;
      dc_cls            <= '0;
      rd_full_o         <= '0;
      rd_lo_o           <= '0;
      rd_hi_o           <= '0;
      rd_lo1_hi2_o      <= '0;
      rd_hi1_lo2_o      <= '0;
      wr_full_o         <= '0;
      wr_lo_o           <= '0;
      wr_hi_o           <= '0;
      agen_o            <= '0;
      amod_wr_o         <= '0;
      addr_send_o       <= '0;
      wdata_send_o      <= '0;
      mem_access_o      <= '0;
      ld_return_o       <= '0;
      ld_wr_o           <= '0;
      done_o            <= '0;
      branch_o          <= '0;
      saturation_flag_o <= 1'b0;
    end else begin
      dc_valid_o        <= next_dc_valid;
      dc_cls            <= next_dc_cls;
      rd_full_o         <= next_rd_full;
      rd_lo_o           <= next_rd_lo;
      rd_hi_o           <= next_rd_hi;
      rd_lo1_hi2_o      <= next_rd_lo1_hi2;
      rd_hi1_lo2_o      <= next_rd_hi1_lo2;
      wr_full_o         <= next_wr_full;
      wr_lo_o           <= next_wr_lo;
      wr_hi_o           <= next_wr_hi;
      agen_o            <= next_agen;
      amod_wr_o         <= next_amod_wr;
      addr_send_o       <= next_addr_send;
      wdata_send_o      <= next_wdata_send;
      mem_access_o      <= next_mem_access;
      ld_return_o       <= next_ld_return;
      ld_wr_o           <= next_ld_wr;
      done_o            <= next_done;
      branch_o          <= next_branch;
      // Set wins over a clear in the same cycle
      saturation_flag_o <= (saturation_flag_o & ~sat_clr_i) | (|next_sat_set);
    end
  end

  // Checks; fetch and split are shared, unit events observed on unit 0
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  wire d0 = dc_valid_o[0] & cond_i[0];
  wire [3:0] c0 = dc_cls[0];

  sequence s_load_tail;
    addr_send_o[0] ##1 mem_access_o[0] ##1 ld_return_o[0] ##1 (ld_wr_o[0] && done_o[0]);
  endsequence
  sequence s_dmpy_reads;
    rd_lo_o[0] ##1 rd_lo1_hi2_o[0] ##1 rd_hi1_lo2_o[0] ##1 rd_hi_o[0];
  endsequence

  property p_fetch_step;
    (dp_adv && !redirect) ##1 dp_adv |=> prog_addr_o == $past(prog_addr_o) + `FPP_PKT_STRIDE;
  endproperty
  a_fetch_step: assert property (p_fetch_step) else $error("fetch address did not step");

  property p_split;
    (dp_valid && !last_ep) |=> dp_valid && dp_left == ($past(dp_left) & ~$past(ep));
  endproperty
  a_split: assert property (p_split) else $error("execute packet split wrong");

  property p_false_cond;
    (dc_valid_o[0] && !cond_i[0]) |=> !wr_full_o[0] && !wr_lo_o[0] && !branch_o[0] && !amod_wr_o[0];
  endproperty
  a_false_cond: assert property (p_false_cond) else $error("false condition wrote");

  property p_load;
    (d0 && c0 == fpp_pkg::cls_load) |=> (agen_o[0] && amod_wr_o[0]) ##1 s_load_tail;
  endproperty
  a_load: assert property (p_load) else $error("load phase order wrong");

  property p_store;
    (d0 && c0 == fpp_pkg::cls_store) |=> ##1 (addr_send_o[0] && wdata_send_o[0])
      ##1 (mem_access_o[0] && done_o[0]);
  endproperty
  a_store: assert property (p_store) else $error("store phase order wrong");

  property p_addsub;
    (d0 && c0 == fpp_pkg::cls_dbl_addsub) |=> rd_lo_o[0] ##1 rd_hi_o[0] ##4 wr_lo_o[0]
      ##1 (wr_hi_o[0] && done_o[0]);
  endproperty
  a_addsub: assert property (p_addsub) else $error("double add timing wrong");

  property p_dmpy;
    (d0 && c0 == fpp_pkg::cls_dbl_mpy) |=> s_dmpy_reads ##5 wr_lo_o[0] ##1 wr_hi_o[0];
  endproperty
  a_dmpy: assert property (p_dmpy) else $error("double multiply timing wrong");

  property p_int32_multiply;
    (d0 && c0 == fpp_pkg::cls_int32_mpy) |=> rd_full_o[0] [*4] ##5 (wr_full_o[0] && done_o[0]);
  endproperty
  a_int32_multiply: assert property (p_int32_multiply) else $error("int multiply timing wrong");

  property p_int_to_double_convert;
    (d0 && c0 == fpp_pkg::cls_int_to_dbl) |=> ##3 wr_lo_o[0] ##1 (wr_hi_o[0] && done_o[0]);
  endproperty
  a_int_to_double_convert: assert property (p_int_to_double_convert) else $error("convert timing wrong");

  property p_single;
    (d0 && c0 == fpp_pkg::cls_single) |=> wr_full_o[0] && done_o[0] && rd_full_o[0];
  endproperty
  a_single: assert property (p_single) else $error("single-cycle not in E1");

  property p_sat;
    (d0 && c0 == fpp_pkg::cls_single) ##1 sat_i[0] |=> saturation_flag_o;
  endproperty
  a_sat: assert property (p_sat) else $error("saturation flag not set");

  property p_branch;
    (d0 && c0 == fpp_pkg::cls_branch) |=> branch_o[0];
  endproperty
  a_branch: assert property (p_branch) else $error("branch not in E1");

endmodule

// ==== sim/fpp_prog_mem.sv ====
/*
  Program memory model: one packet per 0x20 bytes, read one cycle late.
  Assumes the bench fills cls_tab with the slot 0 class of each packet.
*/
`timescale 1ns/1ps
`include "fpp_consts.svh"

module fpp_prog_mem (
  // Clock
  input  wire logic                   core_clk_i,
  // Request from the sequencer
  input  wire logic [31:0]            prog_addr_i,
  input  wire logic                   prog_req_i,
  // Packet back
  output logic      [`FPP_PKT_W-1:0]  prog_data_o
);
  logic [3:0] cls_tab [0:63];

  initial begin
    prog_data_o = '0;
    for (int i = 0; i < 64; i++) cls_tab[i] = 4'h0;
  end

  // Slot 0 on unit 0, slots 1 to 6 parallel no-ops; idle bus toggles
  always @(posedge core_clk_i) begin
    if (prog_req_i) begin
      prog_data_o <= {32'h0000_0000, {6{32'h0000_0080}},
                      24'h00_0000, 4'h8, cls_tab[prog_addr_i[10:5]]};
    end else begin
      prog_data_o <= ~prog_data_o;
    end
  end
endmodule

// ==== sim/float_cpu_pipeline_phases_tb_top.sv ====
/*
  Testbench of the phase sequencer: fetch walk and execute-phase timing.
  Assumes the design and the program memory model are compiled first.
*/
`timescale 1ns/1ps
`include "fpp_consts.svh"
`define FPP_CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module float_cpu_pipeline_phases_tb_top;
  logic core_clk_i, rst_n_i;
  logic [7:0] cond_i;
  logic [`FPP_PKT_W-1:0] prog_data;
  logic [31:0] prog_addr;
  logic prog_req;
  logic [7:0] dc_valid, rd_lo, rd_hi, rd_a, rd_b, wr_lo, wr_hi, agen, amod;
  logic [7:0] a_snd, d_snd, macc, ld_ret, ld_wr, done;
  logic [7:0] rd_full, wr_full, br, sat_i;
  logic sat_flag;
  logic [16:0] ev;
  int n_fail, n_compared;
  int cyc = 0;

  assign ev = {rd_full[0], wr_full[0], br[0],
               rd_lo[0], rd_hi[0], rd_a[0], rd_b[0], wr_lo[0], wr_hi[0], agen[0],
               amod[0], a_snd[0], d_snd[0], macc[0], ld_ret[0], ld_wr[0], done[0]};

  fpp_prog_mem u_mem (.core_clk_i(core_clk_i), .prog_addr_i(prog_addr),
    .prog_req_i(prog_req), .prog_data_o(prog_data));

  fpp_pipeline u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .prog_data_i(prog_data), .prog_addr_o(prog_addr), .prog_req_o(prog_req),
    .cond_i(cond_i), .br_target_i(32'h0000_0000), .sat_i(sat_i), .sat_clr_i(1'b0),
    .dc_valid_o(dc_valid), .rd_full_o(rd_full), .rd_lo_o(rd_lo), .rd_hi_o(rd_hi),
    .rd_lo1_hi2_o(rd_a), .rd_hi1_lo2_o(rd_b), .wr_full_o(wr_full), .wr_lo_o(wr_lo),
    .wr_hi_o(wr_hi), .agen_o(agen), .amod_wr_o(amod), .addr_send_o(a_snd),
    .wdata_send_o(d_snd), .mem_access_o(macc), .ld_return_o(ld_ret), .ld_wr_o(ld_wr),
    .done_o(done), .branch_o(br), .saturation_flag_o(sat_flag));

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check_fetch();
    for (int i = 0; i < 3; i++) begin
      `FPP_CHK("fetch address", 32'h20 * i, prog_addr)
      `FPP_CHK("fetch request", 1'b1, prog_req)
      @(negedge core_clk_i);
    end
  endtask

  // Each nibble of ph is the execute phase in which that event is due
  task automatic run_insn(input string nm, input logic [67:0] ph, input logic cnd,
                          input logic saturation_flag);
    int w;
    logic [16:0] e;
    w = 0;
    while (dc_valid[0] !== 1'b1 && w < 40) begin
      @(negedge core_clk_i);
      w++;
    end
    `FPP_CHK({nm, " decode"}, 1'b1, dc_valid[0])
    cond_i = {8{cnd}};
    for (int k = 1; k <= 10; k++) begin
      @(negedge core_clk_i);
      cond_i = 8'hff;
      sat_i = (k == 1) ? {8{saturation_flag}} : 8'h00;
      for (int j = 0; j < 17; j++) e[16-j] = (ph[67-4*j -: 4] == k);
      `FPP_CHK(nm, e, ev)
    end
    `FPP_CHK({nm, " saturation flag"}, saturation_flag, sat_flag)
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    rst_n_i = 1'b0;
    cond_i = 8'hff;
    sat_i = 8'h00;
    u_mem.cls_tab[62] = 4'h1;
    u_mem.cls_tab[2] = 4'ha;
    u_mem.cls_tab[14] = 4'h4;
    u_mem.cls_tab[26] = 4'hd;
    u_mem.cls_tab[38] = 4'h3;
    u_mem.cls_tab[50] = 4'h4;
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    @(negedge core_clk_i);
    check_fetch();
    run_insn("double add", 68'h00012006700000007, 1'b1, 1'b0);
    // Packet address wraps at 64: keep the old double add out of later windows
    u_mem.cls_tab[2] = 4'h0;
    run_insn("load", 68'h10000000011203455, 1'b1, 1'b0);
    run_insn("double mpy", 68'h00014239a0000000a, 1'b1, 1'b0);
    run_insn("store", 68'h10000000011223003, 1'b1, 1'b0);
    run_insn("false load", 68'h10000000010000000, 1'b0, 1'b0);
    run_insn("single sat", 68'h11000000000000001, 1'b1, 1'b1);
    test_done();
  end
endmodule
